// [common/hib_pkg.sv]
package hib_pkg;
   localparam int unsigned COUNT_W = 32;
   localparam int unsigned TRIM_W = 16;
   localparam int unsigned MEM_WORDS = 64;
   localparam int unsigned MEM_AW = 6;
   localparam int unsigned EVENT_W = 4;
   localparam int unsigned XTAL_DIV = 128;
   localparam int unsigned XTAL_DIV_W = 7;
   localparam int unsigned TRIM_CYCLE = 64;
   localparam int unsigned TRIM_CYCLE_W = 6;
   localparam logic [COUNT_W-1:0] COUNT_RESET = 32'h00000000;
   localparam logic [COUNT_W-1:0] MATCH_RESET = 32'hFFFFFFFF;
   localparam logic [COUNT_W-1:0] LOAD_RESET = 32'hFFFFFFFF;
   localparam logic [TRIM_W-1:0] TRIM_RESET = 16'h7FFF;
   localparam logic [TRIM_W-1:0] NOMINAL_DIV = 16'h7FFF;
   localparam int unsigned EV_MATCH_A = 0;
   localparam int unsigned EV_MATCH_B = 1;
   localparam int unsigned EV_LOWBATT = 2;
   localparam int unsigned EV_WAKE_PIN = 3;
   typedef enum {ST_AWAKE, ST_ASLEEP} power_state_t;
endpackage : hib_pkg

// [common/ref_tick_if.sv]
interface ref_tick_if;
   logic enable;
   logic select;
   logic tick;
   modport source (input enable, input select, output tick);
   modport sink (output enable, output select, input tick);
endinterface : ref_tick_if

// [logic/ref_tick_gen.sv]
module ref_tick_gen
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic osc_in,
   ref_tick_if.source tick_bus
);
   import hib_pkg::*;

   logic osc_meta;
   logic osc_sync;
   logic osc_prev;
   logic [XTAL_DIV_W-1:0] div_count;
   logic rise;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         osc_meta <= 1'b0;
         osc_sync <= 1'b0;
         osc_prev <= 1'b0;
      end
      else
      begin
         osc_meta <= osc_in;
         osc_sync <= osc_meta;
         osc_prev <= osc_sync;
      end
   end

   assign rise = osc_sync & ~osc_prev;

   // Divider held at zero while the source is off, so it restarts cleanly
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         div_count <= '0;
      else if (!tick_bus.enable || tick_bus.select)
         div_count <= '0;
      else if (rise)
         div_count <= div_count + 7'h01;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         tick_bus.tick <= 1'b0;
      else if (!tick_bus.enable)
         tick_bus.tick <= 1'b0;
      else if (tick_bus.select)
         tick_bus.tick <= rise;
      else
         tick_bus.tick <= rise && (div_count == XTAL_DIV_W'(XTAL_DIV - 1));
   end
endmodule : ref_tick_gen

// [logic/hib_power_rtc.sv]
module hib_power_rtc
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic osc_input_a,
   input wire logic wake_n,
   input wire logic battery_low,
   input wire logic osc_source_enable,
   input wire logic osc_source_select,
   input wire logic rtc_count_enable,
   input wire logic pin_wake_enable,
   input wire logic match_wake_enable,
   input wire logic lowbatt_detect_enable,
   input wire logic lowbatt_sleep_abort,
   input wire logic sleep_request,
   input wire logic load_write,
   input wire logic [hib_pkg::COUNT_W-1:0] load_wdata,
   input wire logic match_a_write,
   input wire logic [hib_pkg::COUNT_W-1:0] match_a_wdata,
   input wire logic match_b_write,
   input wire logic [hib_pkg::COUNT_W-1:0] match_b_wdata,
   input wire logic trim_write,
   input wire logic [hib_pkg::TRIM_W-1:0] trim_wdata,
   input wire logic mem_write,
   input wire logic [hib_pkg::MEM_AW-1:0] mem_addr,
   input wire logic [hib_pkg::COUNT_W-1:0] mem_wdata,
   input wire logic [hib_pkg::EVENT_W-1:0] event_mask_reg,
   input wire logic event_clear_write,
   input wire logic [hib_pkg::EVENT_W-1:0] event_clear_reg,
   output logic power_off_request_n,
   output logic sleeping,
   output logic [hib_pkg::COUNT_W-1:0] seconds_counter_reg,
   output logic [hib_pkg::COUNT_W-1:0] seconds_match_a_reg,
   output logic [hib_pkg::COUNT_W-1:0] seconds_match_b_reg,
   output logic [hib_pkg::COUNT_W-1:0] seconds_load_reg,
   output logic [hib_pkg::TRIM_W-1:0] predivider_trim_reg,
   output logic [hib_pkg::COUNT_W-1:0] mem_rdata,
   output logic [hib_pkg::EVENT_W-1:0] raw_event_status_reg,
   output logic [hib_pkg::EVENT_W-1:0] masked_event_status_reg,
   output logic irq
);
   import hib_pkg::*;

   ref_tick_if tick_bus ();

   power_state_t state;
   logic wake_meta;
   logic wake_sync;
   logic wake_prev;
   logic batt_meta;
   logic batt_sync;
   logic req_prev;
   logic req_edge;
   logic [TRIM_W-1:0] prediv;
   logic [TRIM_CYCLE_W-1:0] sec_index;
   logic second_pulse;
   logic count_fresh;
   logic hit_a;
   logic hit_b;
   logic wake_edge;
   logic lowbatt_seen;
   logic sleep_ok;
   logic wake_now;
   logic [EVENT_W-1:0] set_events;
   logic [EVENT_W-1:0] clr_events;
   logic [EVENT_W-1:0] next_raw;
   logic [COUNT_W-1:0] mem [MEM_WORDS];

   assign tick_bus.enable = osc_source_enable;
   assign tick_bus.select = osc_source_select;

   ref_tick_gen u_ref_tick (
      .ref_clk (ref_clk),
      .rst_n (rst_n),
      .osc_in (osc_input_a),
      .tick_bus (tick_bus)
   );

   // Pins are asynchronous to ref_clk
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wake_meta <= 1'b1;
         wake_sync <= 1'b1;
         wake_prev <= 1'b1;
         batt_meta <= 1'b0;
         batt_sync <= 1'b0;
      end
      else
      begin
         wake_meta <= wake_n;
         wake_sync <= wake_meta;
         wake_prev <= wake_sync;
         batt_meta <= battery_low;
         batt_sync <= batt_meta;
      end
   end

   assign wake_edge = wake_prev & ~wake_sync;

   // Edge of the request, so a request left high does not re-enter sleep after wake
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         req_prev <= 1'b0;
      else
         req_prev <= sleep_request;
   end

   assign req_edge = sleep_request & ~req_prev;

   // Predivider: reload+1 ticks per second
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prediv <= NOMINAL_DIV;
         sec_index <= '0;
      end
      else if (rtc_count_enable && tick_bus.tick)
      begin
         if (prediv == '0)
         begin
            sec_index <= sec_index + 6'h01;
            if (sec_index == TRIM_CYCLE_W'(TRIM_CYCLE - 2))
               prediv <= predivider_trim_reg;
            else
               prediv <= NOMINAL_DIV;
         end
         else
            prediv <= prediv - 16'h0001;
      end
   end

   assign second_pulse = rtc_count_enable && tick_bus.tick && (prediv == '0);

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         seconds_counter_reg <= COUNT_RESET;
      else if (load_write)
         seconds_counter_reg <= load_wdata;
      else if (second_pulse)
         seconds_counter_reg <= seconds_counter_reg + 32'h00000001;
   end

   // Compare only on a new count value, so a standing match is one event
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         count_fresh <= 1'b0;
      else
         count_fresh <= load_write | second_pulse;
   end

   assign hit_a = count_fresh && (seconds_counter_reg == seconds_match_a_reg);
   assign hit_b = count_fresh && (seconds_counter_reg == seconds_match_b_reg);

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         seconds_match_a_reg <= MATCH_RESET;
         seconds_match_b_reg <= MATCH_RESET;
         seconds_load_reg <= LOAD_RESET;
         predivider_trim_reg <= TRIM_RESET;
      end
      else
      begin
         if (match_a_write)
            seconds_match_a_reg <= match_a_wdata;
         if (match_b_write)
            seconds_match_b_reg <= match_b_wdata;
         if (load_write)
            seconds_load_reg <= load_wdata;
         if (trim_write)
            predivider_trim_reg <= trim_wdata;
      end
   end

   // No reset: contents must survive across wake
   always_ff @(posedge ref_clk)
   begin
      if (mem_write)
         mem[mem_addr] <= mem_wdata;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         mem_rdata <= '0;
      else if (mem_write)
         mem_rdata <= mem_wdata;
      else
         mem_rdata <= mem[mem_addr];
   end

   always_comb
   begin
      set_events = '0;
      set_events[EV_MATCH_A] = hit_a;
      set_events[EV_MATCH_B] = hit_b;
      set_events[EV_LOWBATT] = lowbatt_detect_enable && batt_sync && (state == ST_AWAKE);
      set_events[EV_WAKE_PIN] = wake_edge;
      clr_events = event_clear_write ? event_clear_reg : '0;
      next_raw = (raw_event_status_reg & ~clr_events) | set_events;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         raw_event_status_reg <= '0;
         masked_event_status_reg <= '0;
         irq <= 1'b0;
      end
      else
      begin
         raw_event_status_reg <= next_raw;
         masked_event_status_reg <= next_raw & event_mask_reg;
         irq <= |(next_raw & event_mask_reg);
      end
   end

   assign lowbatt_seen = raw_event_status_reg[EV_LOWBATT] | set_events[EV_LOWBATT];
   assign sleep_ok = (pin_wake_enable | match_wake_enable)
                     && !(lowbatt_sleep_abort && lowbatt_detect_enable && lowbatt_seen);
   assign wake_now = (pin_wake_enable && !wake_sync)
                     || (match_wake_enable && (hit_a || hit_b));

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= ST_AWAKE;
         power_off_request_n <= 1'b1;
         sleeping <= 1'b0;
      end
      else
      begin
         case (state)
            ST_AWAKE:
            begin
               if (req_edge && sleep_ok)
               begin
                  state <= ST_ASLEEP;
                  power_off_request_n <= 1'b0;
                  sleeping <= 1'b1;
               end
            end
            ST_ASLEEP:
            begin
               if (wake_now)
               begin
                  state <= ST_AWAKE;
                  power_off_request_n <= 1'b1;
                  sleeping <= 1'b0;
               end
            end
            default:
            begin
               state <= ST_AWAKE;
               power_off_request_n <= 1'b1;
               sleeping <= 1'b0;
            end
         endcase
      end
   end
endmodule : hib_power_rtc

// [dv/hib_power_rtc_properties.sv]
module hib_checks
   import hib_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic wake_n,
   input wire logic battery_low,
   input wire logic rtc_count_enable,
   input wire logic pin_wake_enable,
   input wire logic match_wake_enable,
   input wire logic lowbatt_detect_enable,
   input wire logic lowbatt_sleep_abort,
   input wire logic sleep_request,
   input wire logic load_write,
   input wire logic [COUNT_W-1:0] load_wdata,
   input wire logic match_a_write,
   input wire logic [COUNT_W-1:0] match_a_wdata,
   input wire logic [EVENT_W-1:0] event_mask_reg,
   input wire logic power_off_request_n,
   input wire logic sleeping,
   input wire logic [COUNT_W-1:0] seconds_counter_reg,
   input wire logic [COUNT_W-1:0] seconds_load_reg,
   input wire logic [COUNT_W-1:0] seconds_match_a_reg,
   input wire logic [EVENT_W-1:0] raw_event_status_reg,
   input wire logic [EVENT_W-1:0] masked_event_status_reg,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   load_sets_count_a: assert property (load_write |=> seconds_counter_reg == $past(load_wdata)
      && seconds_load_reg == $past(load_wdata)) else $error("load value not applied");
   match_readback_a: assert property (match_a_write |=> seconds_match_a_reg == $past(match_a_wdata))
      else $error("match value not stored");
   count_hold_a: assert property (!rtc_count_enable && !load_write |=> $stable(seconds_counter_reg))
      else $error("counter moved while disabled");
   pin_level_a: assert property (power_off_request_n != sleeping)
      else $error("power-off pin disagrees with state");
   sleep_enter_a: assert property ($rose(sleep_request) && !sleeping && !lowbatt_sleep_abort
      && (pin_wake_enable || match_wake_enable) |=> !power_off_request_n) else $error("sleep not entered");
   sleep_refuse_a: assert property ($rose(sleep_request) && !sleeping && (!(pin_wake_enable || match_wake_enable)
      || lowbatt_sleep_abort && lowbatt_detect_enable && raw_event_status_reg[EV_LOWBATT]) |=> !sleeping)
      else $error("sleep entered when it should be refused");
   pin_wake_a: assert property ((sleeping && pin_wake_enable && !wake_n) [*3] |-> ##[1:2] !sleeping)
      else $error("no wake from pin");
   mask_status_a: assert property (masked_event_status_reg == (raw_event_status_reg & $past(event_mask_reg)))
      else $error("masked status wrong");
   irq_or_a: assert property (irq == |masked_event_status_reg)
      else $error("interrupt not OR of masked events");
   lowbatt_flag_a: assert property ((lowbatt_detect_enable && battery_low && !sleeping) [*4]
      |=> raw_event_status_reg[EV_LOWBATT]) else $error("low battery flag not set");
endmodule : hib_checks

// [dv/osc_model.sv]
module osc_model
(
   input wire logic run,
   output logic osc
);
   timeunit 1ns;
   timeprecision 1ns;
   initial osc = 1'b0;
   // Stands low while disabled; 100 ns period, edges on ref_clk falling edges so a second fits the run
   always #50 osc = run ? ~osc : 1'b0;
endmodule : osc_model

// [dv/tb_hib_power_rtc.sv]
module tb_hib_power_rtc
   import hib_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk, rst_n, osc_input_a, wake_n, battery_low, osc_source_enable, osc_source_select, rtc_count_enable;
   logic pin_wake_enable, match_wake_enable, lowbatt_detect_enable, lowbatt_sleep_abort, sleep_request;
   logic load_write, match_a_write, match_b_write, trim_write, mem_write, event_clear_write;
   logic [COUNT_W-1:0] load_wdata, match_a_wdata, match_b_wdata, mem_wdata, mem_rdata;
   logic [COUNT_W-1:0] seconds_counter_reg, seconds_match_a_reg, seconds_match_b_reg, seconds_load_reg;
   logic [TRIM_W-1:0] trim_wdata, predivider_trim_reg;
   logic [MEM_AW-1:0] mem_addr;
   logic [EVENT_W-1:0] event_mask_reg, event_clear_reg, raw_event_status_reg, masked_event_status_reg;
   logic power_off_request_n, sleeping, irq;
   int bad_count, comparisons;
   hib_power_rtc dut_u (.ref_clk, .rst_n, .osc_input_a, .wake_n, .battery_low, .osc_source_enable,
      .osc_source_select, .rtc_count_enable, .pin_wake_enable, .match_wake_enable, .lowbatt_detect_enable,
      .lowbatt_sleep_abort, .sleep_request, .load_write, .load_wdata, .match_a_write, .match_a_wdata,
      .match_b_write, .match_b_wdata, .trim_write, .trim_wdata, .mem_write, .mem_addr, .mem_wdata,
      .event_mask_reg, .event_clear_write, .event_clear_reg, .power_off_request_n, .sleeping,
      .seconds_counter_reg, .seconds_match_a_reg, .seconds_match_b_reg, .seconds_load_reg,
      .predivider_trim_reg, .mem_rdata, .raw_event_status_reg, .masked_event_status_reg, .irq);
   osc_model osc_u (.run(osc_source_enable), .osc(osc_input_a));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : check
   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : idle
   // k: 0 load, 1 match A, 2 match B, 3 trim, 4 memory, 5 event clear
   task automatic put(input int k, input logic [31:0] d);
      @(negedge ref_clk);
      {load_wdata, match_a_wdata, match_b_wdata, mem_wdata} = {4{d}};
      trim_wdata = d[15:0];
      event_clear_reg = d[3:0];
      {event_clear_write, mem_write, trim_write, match_b_write, match_a_write, load_write} = 6'(1 << k);
      @(negedge ref_clk);
      {event_clear_write, mem_write, trim_write, match_b_write, match_a_write, load_write} = 6'h00;
   endtask : put
   task automatic sleep_req;
      @(negedge ref_clk);
      sleep_request = 1'b1;
      @(negedge ref_clk);
      sleep_request = 1'b0;
   endtask : sleep_req
   task automatic report_and_stop;
      if (bad_count == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial
   begin
      #4000000;
      bad_count++;
      report_and_stop();
   end
   initial
   begin
      {rst_n, battery_low, osc_source_enable, osc_source_select, rtc_count_enable, pin_wake_enable} = '0;
      {match_wake_enable, lowbatt_detect_enable, lowbatt_sleep_abort, sleep_request, mem_addr} = '0;
      {load_write, match_a_write, match_b_write, trim_write, mem_write, event_clear_write} = '0;
      {load_wdata, match_a_wdata, match_b_wdata, mem_wdata, trim_wdata, event_mask_reg, event_clear_reg} = '0;
      wake_n = 1'b1;
      idle(4);
      rst_n = 1'b1;
      idle(2);
      check(predivider_trim_reg, 32'h00007FFF);
      check(seconds_match_a_reg, 32'hFFFFFFFF);
      check(seconds_load_reg, 32'hFFFFFFFF);
      check(power_off_request_n, 32'h1);
      mem_addr = 6'h3F;
      put(4, 32'hA5A50F0F);
      mem_addr = 6'h00;
      put(4, 32'h12345678);
      mem_addr = 6'h3F;
      idle(1);
      check(mem_rdata, 32'hA5A50F0F);
      mem_addr = 6'h00;
      idle(1);
      check(mem_rdata, 32'h12345678);
      put(3, 32'h8001);
      check(predivider_trim_reg, 32'h00008001);
      event_mask_reg = 4'h1;
      put(1, 32'h10);
      put(2, 32'h20);
      check(seconds_match_b_reg, 32'h20);
      put(0, 32'h10);
      check(seconds_counter_reg, 32'h10);
      idle(2);
      check(raw_event_status_reg, 32'h1);
      check(irq, 32'h1);
      put(0, 32'h20);
      idle(2);
      check(raw_event_status_reg, 32'h3);
      check(masked_event_status_reg, 32'h1);
      put(5, 32'h1);
      check(raw_event_status_reg, 32'h2);
      check(irq, 32'h0);
      put(0, 32'h0);
      put(5, 32'hF);
      sleep_req();
      check(sleeping, 32'h0);
      pin_wake_enable = 1'b1;
      sleep_req();
      check(power_off_request_n, 32'h0);
      wake_n = 1'b0;
      idle(4);
      check(power_off_request_n, 32'h1);
      check(raw_event_status_reg, 32'h8);
      wake_n = 1'b1;
      pin_wake_enable = 1'b0;
      match_wake_enable = 1'b1;
      put(1, 32'h40);
      sleep_req();
      check(sleeping, 32'h1);
      put(0, 32'h40);
      idle(3);
      check(sleeping, 32'h0);
      match_wake_enable = 1'b0;
      put(5, 32'hF);
      lowbatt_detect_enable = 1'b1;
      battery_low = 1'b1;
      idle(5);
      check(raw_event_status_reg[EV_LOWBATT], 32'h1);
      lowbatt_sleep_abort = 1'b1;
      pin_wake_enable = 1'b1;
      sleep_req();
      check(sleeping, 32'h0);
      battery_low = 1'b0;
      idle(3);
      put(5, 32'hF);
      sleep_req();
      check(sleeping, 32'h1);
      battery_low = 1'b1;
      idle(6);
      check(raw_event_status_reg[EV_LOWBATT], 32'h0);
      wake_n = 1'b0;
      idle(4);
      check(sleeping, 32'h0);
      wake_n = 1'b1;
      check(seconds_counter_reg, 32'h40);
      // Oscillator input, so no settling wait; ticks run first with counting held off
      {osc_source_enable, osc_source_select} = 2'h3;
      idle(40);
      check(seconds_counter_reg, 32'h40);
      rtc_count_enable = 1'b1;
      // One second is 32768 ticks, one tick every two cycles here
      idle(65500);
      check(seconds_counter_reg, 32'h40);
      idle(60);
      check(seconds_counter_reg, 32'h41);
      report_and_stop();
   end
endmodule : tb_hib_power_rtc
bind hib_power_rtc hib_checks chk_u (.ref_clk, .rst_n, .wake_n, .battery_low, .rtc_count_enable,
   .pin_wake_enable, .match_wake_enable, .lowbatt_detect_enable, .lowbatt_sleep_abort, .sleep_request,
   .load_write, .load_wdata, .match_a_write, .match_a_wdata, .event_mask_reg, .power_off_request_n,
   .sleeping, .seconds_counter_reg, .seconds_load_reg, .seconds_match_a_reg, .raw_event_status_reg,
   .masked_event_status_reg, .irq);
